// ### hw/dic_pkg.sv
package dic_pkg;

   typedef struct packed {
      logic [5:0]  dscp;
      logic [15:0] len;
   } dic_pkt_t;

   typedef enum logic [1:0] {IN_A, IN_B, IN_C, IN_D} dic_input_t;

   localparam int          KBYTE        = 1024;
   localparam int          QBW          = 24;
   localparam int          NUM_Q        = 4;
   localparam int          NUM_METER    = 5;

   // Code points
   localparam logic [5:0]  CP_EF_RST     = 6'h09;
   localparam logic [5:0]  CP_SHAPE_RST  = 6'h0c;
   localparam logic [5:0]  CP_AF21_RST   = 6'h0d;
   localparam logic [5:0]  CP_REMARK_RST = 6'h08;

   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_FILTER    = 8'h04;
   localparam logic [7:0]  OFS_PRIO      = 8'h08;
   localparam logic [7:0]  OFS_PROF_EF   = 8'h0c;
   localparam logic [7:0]  OFS_PROF_SHP  = 8'h10;
   localparam logic [7:0]  OFS_PROF_AF21 = 8'h14;
   localparam logic [7:0]  OFS_THR_SHP   = 8'h18;
   localparam logic [7:0]  OFS_THR_AF21  = 8'h1c;
   localparam logic [7:0]  OFS_RED_MIN   = 8'h20;
   localparam logic [7:0]  OFS_RED_MAX   = 8'h24;
   localparam logic [7:0]  OFS_TALLY     = 8'h28;
   localparam logic [7:0]  OFS_DEPTH_A   = 8'h2c;
   localparam logic [7:0]  OFS_DEPTH_B   = 8'h30;
   localparam logic [7:0]  OFS_DEPTH_C   = 8'h34;
   localparam logic [7:0]  OFS_DEPTH_D   = 8'h38;

   // Field positions
   localparam int          CTRL_HEAD_DROP = 0;
   localparam int          FLT_A_LSB      = 0;
   localparam int          FLT_B_LSB      = 8;
   localparam int          FLT_C_LSB      = 16;
   localparam int          FLT_MARK_LSB   = 24;
   localparam int          PROF_RATE_LSB  = 0;
   localparam int          PROF_BURST_LSB = 16;

   // Reset values
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [7:0]  PRIO_A_RST   = 8'h14;
   localparam logic [7:0]  PRIO_B_RST   = 8'h28;
   localparam logic [7:0]  PRIO_C_RST   = 8'h14;
   localparam logic [7:0]  PRIO_D_RST   = 8'h0a;
   localparam logic [31:0] PROF_RST     = 32'h0600_0100;
   localparam logic [QBW-1:0] THR_SHP_RST  = QBW'(10 * KBYTE);
   localparam logic [QBW-1:0] THR_AF21_RST = QBW'(20 * KBYTE);
   localparam logic [QBW-1:0] RED_MIN_RST  = QBW'(20 * KBYTE);
   localparam logic [QBW-1:0] RED_MAX_RST  = QBW'(40 * KBYTE);
   localparam logic [15:0] LFSR_SEED    = 16'hace1;
   localparam logic [15:0] LFSR_TAPS    = 16'hb400;

endpackage : dic_pkg

// ### hw/dic_token_meter.sv
`timescale 1ns/1ps
`default_nettype none

// Token bucket with 8 fraction bits; rate is bytes per clock times 256
module dic_token_meter
   import dic_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] rate,
   input  wire logic [15:0] burst,
   input  wire logic [15:0] len,
   input  wire logic        consume,
   output var  logic        conform
);

   logic [31:0] tokens;
   logic [31:0] next_tokens;
   logic [31:0] need;
   logic [31:0] cap;
   logic [32:0] fill;

   assign need = {8'h00, len, 8'h00};
   assign cap  = {8'h00, burst, 8'h00};

   // Exactly one of two outcomes per packet
   assign conform = tokens >= need;

   always_comb begin
      fill = {1'b0, tokens} + {17'h0_0000, rate};
      if (fill > {1'b0, cap}) begin
         next_tokens = cap;
      end else begin
         next_tokens = fill[31:0];
      end
      // Guarantee meters may overdraw; they floor at empty
      if (consume) begin
         if (next_tokens > need) begin
            next_tokens = next_tokens - need;
         end else begin
            next_tokens = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tokens <= 32'h0000_0000;
      end else begin
         tokens <= next_tokens;
      end
   end

endmodule : dic_token_meter

`default_nettype wire

// ### hw/dic_conditioner.sv
`timescale 1ns/1ps
`default_nettype none

module dic_conditioner
   import dic_pkg::*;
#(
   parameter int QDEPTH = 16,
   parameter int AW     = 8
)(
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   input  wire logic        in_valid,
   input  wire dic_pkt_t    in_pkt,
   output var  logic        in_ready,
   output var  logic        out_valid,
   output var  dic_pkt_t    out_pkt,
   input  wire logic        out_ready
);

   localparam int PW = $clog2(QDEPTH);
   localparam logic [PW:0] QFULL = (PW+1)'(QDEPTH);

   ////////////////////////////////////////////////////////////////////////
   // Configuration and status registers

   logic [31:0]    ctrl;
   logic [31:0]    filter;
   logic [7:0]     prio [NUM_Q];
   logic [31:0]    prof [3];
   logic [QBW-1:0] thr_shp;
   logic [QBW-1:0] thr_af21;
   logic [QBW-1:0] red_min;
   logic [QBW-1:0] red_max;
   logic [31:0]    discard_tally;
   logic           wr_pend;
   logic [AW-1:0]  wr_addr;
   logic [31:0]    rd_word;
   logic           addr_ok;
   logic           tally_inc;

   logic [QBW-1:0] qbytes [NUM_Q];

   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (haddr[AW-1:0])
         OFS_CTRL:      rd_word = ctrl;
         OFS_FILTER:    rd_word = filter;
         OFS_PRIO:      rd_word = {prio[3], prio[2], prio[1], prio[0]};
         OFS_PROF_EF:   rd_word = prof[0];
         OFS_PROF_SHP:  rd_word = prof[1];
         OFS_PROF_AF21: rd_word = prof[2];
         OFS_THR_SHP:   rd_word = 32'(thr_shp);
         OFS_THR_AF21:  rd_word = 32'(thr_af21);
         OFS_RED_MIN:   rd_word = 32'(red_min);
         OFS_RED_MAX:   rd_word = 32'(red_max);
         OFS_TALLY:     rd_word = discard_tally;
         OFS_DEPTH_A:   rd_word = 32'(qbytes[0]);
         OFS_DEPTH_B:   rd_word = 32'(qbytes[1]);
         OFS_DEPTH_C:   rd_word = 32'(qbytes[2]);
         OFS_DEPTH_D:   rd_word = 32'(qbytes[3]);
         default:       rd_word = 32'h0000_0000;
      endcase
   end

   // Zero-wait slave: read data is fetched in the address phase
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         wr_pend   <= 1'b0;
         wr_addr   <= '0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend   <= addr_ok && hwrite;
         wr_addr   <= haddr[AW-1:0];
         if (addr_ok && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl     <= CTRL_RST;
         filter   <= {2'b00, CP_REMARK_RST, 2'b00, CP_AF21_RST,
                      2'b00, CP_SHAPE_RST, 2'b00, CP_EF_RST};
         prio[0]  <= PRIO_A_RST;
         prio[1]  <= PRIO_B_RST;
         prio[2]  <= PRIO_C_RST;
         prio[3]  <= PRIO_D_RST;
         prof[0]  <= PROF_RST;
         prof[1]  <= PROF_RST;
         prof[2]  <= PROF_RST;
         thr_shp  <= THR_SHP_RST;
         thr_af21 <= THR_AF21_RST;
         red_min  <= RED_MIN_RST;
         red_max  <= RED_MAX_RST;
      end else if (wr_pend) begin
         unique case (wr_addr)
            OFS_CTRL:      ctrl <= hwdata;
            OFS_FILTER:    filter <= hwdata & 32'h3f3f_3f3f;
            OFS_PRIO: begin
               prio[0] <= hwdata[7:0];
               prio[1] <= hwdata[15:8];
               prio[2] <= hwdata[23:16];
               prio[3] <= hwdata[31:24];
            end
            OFS_PROF_EF:   prof[0] <= hwdata;
            OFS_PROF_SHP:  prof[1] <= hwdata;
            OFS_PROF_AF21: prof[2] <= hwdata;
            OFS_THR_SHP:   thr_shp <= hwdata[QBW-1:0];
            OFS_THR_AF21:  thr_af21 <= hwdata[QBW-1:0];
            OFS_RED_MIN:   red_min <= hwdata[QBW-1:0];
            OFS_RED_MAX:   red_max <= hwdata[QBW-1:0];
            default:       ;
         endcase
      end
   end

   // A write clears the tally; a discard in the same cycle still counts
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         discard_tally <= 32'h0000_0000;
      end else if (wr_pend && wr_addr == OFS_TALLY) begin
         discard_tally <= tally_inc ? 32'h0000_0001 : 32'h0000_0000;
      end else if (tally_inc) begin
         discard_tally <= discard_tally + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Meters: 0 EF ingress, 1 AF21 ingress, 2 shaper, 3/4 guarantees

   logic [15:0] m_rate  [NUM_METER];
   logic [15:0] m_burst [NUM_METER];
   logic [15:0] m_len   [NUM_METER];
   logic        m_cons  [NUM_METER];
   logic        m_ok    [NUM_METER];
   int unsigned m_prof  [NUM_METER];

   assign m_prof = '{0, 2, 1, 0, 2};

   for (genvar g = 0; g < NUM_METER; g++) begin : g_meter
      assign m_rate[g]  = prof[m_prof[g]][PROF_RATE_LSB +: 16];
      assign m_burst[g] = prof[m_prof[g]][PROF_BURST_LSB +: 16];
      dic_token_meter u_meter (
         .clk     (clk),
         .reset_n (reset_n),
         .rate    (m_rate[g]),
         .burst   (m_burst[g]),
         .len     (m_len[g]),
         .consume (m_cons[g]),
         .conform (m_ok[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Classifier, action stage and droppers (strictly feed-forward)

   dic_pkt_t       q_mem [NUM_Q][QDEPTH];
   logic [PW-1:0]  q_wr  [NUM_Q];
   logic [PW-1:0]  q_rd  [NUM_Q];
   logic [PW:0]    q_cnt [NUM_Q];
   dic_pkt_t       q_head[NUM_Q];
   logic           pop   [NUM_Q];

   logic           acc;
   dic_input_t     path;
   logic           enq;
   dic_pkt_t       enq_pkt;
   logic [15:0]    lfsr;
   logic [QBW-1:0] red_span;
   logic [QBW-1:0] red_excess;
   logic [QBW+15:0] red_prod;
   logic           red_drop;

   assign acc = in_valid && in_ready;

   always_comb begin
      if (in_pkt.dscp == filter[FLT_A_LSB +: 6]) begin
         path = IN_A;
      end else if (in_pkt.dscp == filter[FLT_B_LSB +: 6]) begin
         path = IN_B;
      end else if (in_pkt.dscp == filter[FLT_C_LSB +: 6]) begin
         path = IN_C;
      end else begin
         path = IN_D;
      end
   end

   // Linear drop chance between the two depths, certain above the max
   assign red_span   = red_max - red_min;
   assign red_excess = qbytes[3] - red_min;
   assign red_prod   = lfsr * red_span;

   always_comb begin
      red_drop = 1'b0;
      if (qbytes[3] > red_max) begin
         red_drop = 1'b1;
      end else if (qbytes[3] > red_min) begin
         red_drop = red_prod[QBW+15:16] < red_excess;
      end
   end

   assign m_len[0]  = in_pkt.len;
   assign m_len[1]  = in_pkt.len;
   assign m_cons[0] = acc && path == IN_A && m_ok[0];
   assign m_cons[1] = acc && path == IN_C && m_ok[1];

   always_comb begin
      enq       = 1'b0;
      tally_inc = 1'b0;
      enq_pkt   = in_pkt;
      unique case (path)
         IN_A: begin
            enq       = acc && m_ok[0];
            tally_inc = acc && !m_ok[0];
         end
         IN_B: begin
            enq = acc && !(qbytes[1] > thr_shp);
         end
         IN_C: begin
            if (!m_ok[1]) begin
               enq_pkt.dscp = filter[FLT_MARK_LSB +: 6];
            end
            enq = acc && !(qbytes[2] > thr_af21);
         end
         IN_D: begin
            enq = acc && !red_drop;
         end
      endcase
      // Descriptor storage full is a plain tail drop
      if (q_cnt[path] == QFULL) begin
         enq = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lfsr <= LFSR_SEED;
      end else begin
         lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         in_ready <= 1'b0;
      end else begin
         in_ready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Queues A..D feeding arbiter inputs A..D

   logic head_drop;

   for (genvar q = 0; q < NUM_Q; q++) begin : g_queue
      logic wr_en;
      logic rd_en;
      assign q_head[q] = q_mem[q][q_rd[q]];
      assign wr_en = enq && path == dic_input_t'(q);
      assign rd_en = pop[q] || (q == 3 && head_drop);

      always_ff @(posedge clk) begin
         if (wr_en) begin
            q_mem[q][q_wr[q]] <= enq_pkt;
         end
      end

      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            q_wr[q]   <= '0;
            q_rd[q]   <= '0;
            q_cnt[q]  <= '0;
            qbytes[q] <= '0;
         end else begin
            if (wr_en) begin
               q_wr[q] <= q_wr[q] + 1'b1;
            end
            if (rd_en) begin
               q_rd[q] <= q_rd[q] + 1'b1;
            end
            q_cnt[q]  <= q_cnt[q] + (PW+1)'(wr_en) - (PW+1)'(rd_en);
            qbytes[q] <= qbytes[q]
                         + (wr_en ? QBW'(enq_pkt.len) : '0)
                         - (rd_en ? QBW'(q_head[q].len) : '0);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Four-input arbiter

   logic [1:0] last;
   logic       issue;
   logic       found;
   logic [1:0] pick;
   logic [3:0] elig;
   logic [3:0] gok;

   // Key: priority, then guarantee still owed, then not served last
   function automatic logic [9:0] arb_key(input logic [7:0] p,
                                          input logic g,
                                          input logic fresh);
      arb_key = {p, g, fresh};
   endfunction : arb_key

   assign m_len[2] = q_head[1].len;
   assign m_len[3] = q_head[0].len;
   assign m_len[4] = q_head[2].len;

   always_comb begin
      for (int i = 0; i < NUM_Q; i++) begin
         elig[i] = q_cnt[i] != '0;
      end
      elig[1] = elig[1] && m_ok[2];
      gok     = {1'b0, m_ok[4], 1'b0, m_ok[3]};
   end

   always_comb begin
      logic [9:0] best;
      logic [9:0] k;
      best  = '0;
      k     = '0;
      found = 1'b0;
      pick  = 2'd0;
      for (int i = 0; i < NUM_Q; i++) begin
         k = arb_key(prio[i], gok[i], 2'(i) != last);
         if (elig[i] && (!found || k > best)) begin
            found = 1'b1;
            best  = k;
            pick  = 2'(i);
         end
      end
   end

   assign issue = !out_valid || out_ready;

   // Arbiter grant must hold before a pop; queue B also needs the shaper grant, folded into elig
   always_comb begin
      for (int i = 0; i < NUM_Q; i++) begin
         pop[i] = issue && found && pick == 2'(i);
      end
   end

   assign m_cons[2] = pop[1];
   assign m_cons[3] = pop[0];
   assign m_cons[4] = pop[2];

   // Optional head dropper behind the best-effort queue
   assign head_drop = ctrl[CTRL_HEAD_DROP] && q_cnt[3] != '0
                      && qbytes[3] > red_max && !pop[3];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_pkt   <= '0;
         last      <= 2'd0;
      end else if (issue) begin
         out_valid <= found;
         if (found) begin
            out_pkt <= q_head[pick];
            last    <= pick;
         end
      end
   end

endmodule : dic_conditioner

`default_nettype wire

// ### bench/dic_checker.sv
`timescale 1ns/1ps
`default_nettype none

module dic_checker
   import dic_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        in_valid,
   input wire dic_pkt_t    in_pkt,
   input wire logic        in_ready,
   input wire logic        out_valid,
   input wire dic_pkt_t    out_pkt,
   input wire logic        out_ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////////////////
   sequence s_rd_taken;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence s_stall;
      out_valid && !out_ready;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   chk_out_hold: assert property (
      s_stall |=> out_valid && $stable(out_pkt))
      else $error("output descriptor moved while stalled");
   chk_out_release: assert property (
      $fell(out_valid) |-> $past(out_ready))
      else $error("output descriptor withdrawn unaccepted");
   // Ingress never stalls: every drop is a decision, not back-pressure
   chk_in_open: assert property (
      $past(reset_n) |-> in_ready)
      else $error("ingress not ready");
   chk_bus_ready: assert property (
      $past(reset_n) |-> hreadyout)
      else $error("bus wait state seen");
   chk_bus_okay: assert property (
      hresp == 1'b0)
      else $error("bus error response");
   chk_rdata_hold: assert property (
      !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data changed without a read");
   chk_unmapped_zero: assert property (
      s_rd_taken ##0 (haddr[7:0] >= 8'h3c) |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_default_flow: assert property (
      in_valid && in_pkt.dscp == 6'h00 && !out_valid |-> ##[1:2] out_valid)
      else $error("best effort packet lost with idle output");
endmodule : dic_checker

`default_nettype wire

// ### bench/dic_sink.sv
`timescale 1ns/1ps
`default_nettype none

// Downstream forwarding path; stall holds back acceptance
module dic_sink
   import dic_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     reset_n,
   input  wire logic     stall,
   input  wire logic     out_valid,
   input  wire dic_pkt_t out_pkt,
   output var  logic     out_ready
);
   dic_pkt_t rx[$];

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall;
         if (out_valid && out_ready) begin
            rx.push_back(out_pkt);
         end
      end
   end
endmodule : dic_sink

`default_nettype wire

// ### bench/diffserv_ingress_conditioner_bench.sv
`timescale 1ns/1ps
`default_nettype none

module diffserv_ingress_conditioner_bench
   import dic_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        in_valid = 1'b0;
   dic_pkt_t    in_pkt = '0;
   logic        in_ready;
   logic        out_valid;
   dic_pkt_t    out_pkt;
   logic        out_ready;
   logic        stall = 1'b0;
   logic [31:0] d;
   int          failures = 0;
   int          compares = 0;

   always #2.5 clk = ~clk;

   dic_conditioner u_dut (
      .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .in_valid(in_valid), .in_pkt(in_pkt),
      .in_ready(in_ready), .out_valid(out_valid), .out_pkt(out_pkt),
      .out_ready(out_ready));

   dic_sink u_sink (
      .clk(clk), .reset_n(reset_n), .stall(stall), .out_valid(out_valid),
      .out_pkt(out_pkt), .out_ready(out_ready));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic ahb(input logic wr_en, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr_en;
      haddr <= {24'h0, a};
      hwdata <= ~hwdata;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      ahb(1'b1, a, v, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0, d);
      check($sformatf("register %h", a), exp, d);
   endtask : rdc

   // Released descriptor lines flip so a stale value never looks valid
   task automatic send(input logic [5:0] cp, input logic [15:0] ln);
      @(posedge clk);
      in_valid <= 1'b1;
      in_pkt <= '{dscp: cp, len: ln};
      @(posedge clk);
      in_valid <= 1'b0;
      in_pkt <= dic_pkt_t'(~in_pkt);
   endtask : send

   task automatic pop(input logic [5:0] cp, input logic [15:0] ln);
      dic_pkt_t p;
      for (int n = 0; n < 400 && u_sink.rx.size() == 0; n++) begin
         @(posedge clk);
      end
      p = '1;
      if (u_sink.rx.size() != 0) begin
         p = u_sink.rx.pop_front();
      end
      check("out dscp", 32'(cp), 32'(p.dscp));
      check("out len", 32'(ln), 32'(p.len));
   endtask : pop

   task automatic none_out(input int cycles);
      repeat (cycles) @(posedge clk);
      check("extra outputs", 32'h0, 32'(u_sink.rx.size()));
   endtask : none_out

   // Threshold 1: the second packet enters an empty queue, the third is shed
   task automatic thr(input logic [7:0] t, input logic [7:0] dq,
                      input logic [5:0] cp);
      wr(t, 32'h1);
      rdc(t, 32'h1);
      stall <= 1'b1;
      repeat (3) send(cp, 16'h0040);
      rdc(dq, 32'h40);
      stall <= 1'b0;
      pop(cp, 16'h0040);
      pop(cp, 16'h0040);
      none_out(20);
   endtask : thr

   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (50000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      rdc(OFS_FILTER, 32'h080d_0c09);
      rdc(OFS_PRIO, 32'h0a14_2814);
      rdc(OFS_PROF_EF, PROF_RST);
      rdc(OFS_THR_SHP, 32'h0000_2800);
      rdc(OFS_THR_AF21, 32'h0000_5000);
      rdc(OFS_RED_MIN, 32'h0000_5000);
      rdc(OFS_RED_MAX, 32'h0000_a000);
      rdc(8'h40, 32'h0);
      wr(OFS_DEPTH_A, 32'hffff_ffff);
      rdc(OFS_DEPTH_A, 32'h0);
      // Buckets start empty; let them fill to the burst size
      repeat (2000) @(posedge clk);
      send(6'h00, 16'h0040);
      pop(6'h00, 16'h0040);
      send(CP_SHAPE_RST, 16'h0040);
      pop(CP_SHAPE_RST, 16'h0040);
      send(CP_EF_RST, 16'h0064);
      pop(CP_EF_RST, 16'h0064);
      send(CP_AF21_RST, 16'h0064);
      pop(CP_AF21_RST, 16'h0064);
      wr(OFS_PROF_EF, 32'h0600_0000);
      wr(OFS_TALLY, 32'h0);
      send(CP_EF_RST, 16'h03e8);
      send(CP_EF_RST, 16'h03e8);
      pop(CP_EF_RST, 16'h03e8);
      none_out(20);
      rdc(OFS_TALLY, 32'h1);
      wr(OFS_PROF_AF21, 32'h0600_0000);
      send(CP_AF21_RST, 16'h03e8);
      send(CP_AF21_RST, 16'h03e8);
      pop(CP_AF21_RST, 16'h03e8);
      pop(CP_REMARK_RST, 16'h03e8);
      wr(OFS_PROF_EF, PROF_RST);
      wr(OFS_PROF_AF21, PROF_RST);
      repeat (1600) @(posedge clk);
      stall <= 1'b1;
      send(6'h00, 16'h0040);
      repeat (4) @(posedge clk);
      send(CP_AF21_RST, 16'h0040);
      send(CP_SHAPE_RST, 16'h0040);
      send(6'h00, 16'h0041);
      stall <= 1'b0;
      pop(6'h00, 16'h0040);
      pop(CP_SHAPE_RST, 16'h0040);
      pop(CP_AF21_RST, 16'h0040);
      pop(6'h00, 16'h0041);
      wr(OFS_PROF_SHP, 32'h0064_0100);
      repeat (10) @(posedge clk);
      send(CP_SHAPE_RST, 16'h0064);
      send(CP_SHAPE_RST, 16'h0064);
      pop(CP_SHAPE_RST, 16'h0064);
      none_out(60);
      pop(CP_SHAPE_RST, 16'h0064);
      wr(OFS_PROF_SHP, PROF_RST);
      repeat (200) @(posedge clk);
      thr(OFS_THR_SHP, OFS_DEPTH_B, CP_SHAPE_RST);
      thr(OFS_THR_AF21, OFS_DEPTH_C, CP_AF21_RST);
      wr(OFS_RED_MIN, 32'h0);
      thr(OFS_RED_MAX, OFS_DEPTH_D, 6'h00);
      // Head dropping on queue D: the first arrival is held at the output, the two behind it are shed from the head
      wr(OFS_CTRL, 32'h1);
      rdc(OFS_CTRL, 32'h1);
      stall <= 1'b1;
      repeat (3) send(6'h00, 16'h0040);
      rdc(OFS_DEPTH_D, 32'h0);
      stall <= 1'b0;
      pop(6'h00, 16'h0040);
      none_out(20);
      end_sim();
   end
endmodule : diffserv_ingress_conditioner_bench

bind dic_conditioner dic_checker u_chk (
   .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .in_valid(in_valid), .in_pkt(in_pkt), .in_ready(in_ready),
   .out_valid(out_valid), .out_pkt(out_pkt), .out_ready(out_ready));

`default_nettype wire
